// [logic/sic_top.v]
`timescale 1ns/1ps
`include "sic_defines.vh"

// Plain synchronous FIFO; data sits in an array of its own
module sic_fifo #(
  parameter W = 21,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Fill side
  input wire s_valid,
  output wire s_ready,
  input wire [W-1:0] s_data,
  // Drain side
  output wire m_valid,
  input wire m_ready,
  output wire [W-1:0] m_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  assign s_ready = (cnt_r != D);
  assign m_valid = (cnt_r != 0);
  assign m_data = mem[rp_r];

  // Pointers wrap at depth, so depth need not be a power of two
  always @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wp_r] <= s_data;
        wp_r <= (wp_r == D - 1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop)
        rp_r <= (rp_r == D - 1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

module sic_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial pins
  output reg serial_clock,
  output wire mosi,
  input wire miso,
  output reg [3:0] peripheral_select_lines_n,
  input wire select_input_n,
  // Flags from the surrounding controller
  input wire mode_fault_evt,
  input wire [3:0] dma_flags,
  // Interrupt
  output wire irq
);
  localparam S_IDLE = 3'h0;
  localparam S_LEAD = 3'h1;
  localparam S_SHIFT = 3'h2;
  localparam S_GAP = 3'h3;
  localparam S_SWITCH = 3'h4;

  reg [31:0] mode_r;
  reg [31:0] cfg_r [0:3];
  reg [9:0] mask_r;
  reg rxfull_r, ovr_r, mode_fault_flag_r, selrise_r;
  reg [15:0] rxdata_r;
  reg [3:0] rxpcs_r;
  reg miso_s1_r, miso_s2_r, nss_s1_r, nss_s2_r, nss_d_r;
  reg [2:0] st_r;
  reg [13:0] cnt_r;
  reg [4:0] bit_r;
  reg [15:0] sh_r, rxsh_r;
  reg cs_act_r, cur_last_r;
  reg cap1_r, cap2_r, capl1_r, capl2_r;
  reg [3:0] cur_pcs_r;
  integer i;

  // Config register index for a select code (decoded groups of four)
  function [1:0] cfg_idx;
    input [3:0] pcs;
    input dec;
    begin
      if (dec)
        cfg_idx = pcs[3:2];
      else if (!pcs[0])
        cfg_idx = 2'h0;
      else if (!pcs[1])
        cfg_idx = 2'h1;
      else if (!pcs[2])
        cfg_idx = 2'h2;
      else
        cfg_idx = 2'h3;
    end
  endfunction

  // Transmit FIFO: {last flag, select code, data}
  wire tx_in_valid, tx_in_ready, tx_valid, tx_pop;
  wire [20:0] tx_in, tx_word;
  sic_fifo #(.W(21), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_valid(tx_in_valid),
    .s_ready(tx_in_ready),
    .s_data(tx_in),
    .m_valid(tx_valid),
    .m_ready(tx_pop),
    .m_data(tx_word)
  );

  // Write channel: both halves taken together; a full FIFO stalls only transmit data writes
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
               (s_axi_awaddr != `SIC_OFS_TXDATA || tx_in_ready);
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  wire [31:0] wm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd = s_axi_wdata & wm;
  wire wr_cfg = wr_go && s_axi_awaddr[7:4] == 4'h3 &&
                s_axi_awaddr[1:0] == 2'h0;
  wire [1:0] wr_ci = s_axi_awaddr[3:2];
  assign tx_in_valid = wr_go && s_axi_awaddr == `SIC_OFS_TXDATA;
  assign tx_in = {wd[`SIC_T_LAST], wd[19:16], wd[15:0]};

  // Read channel
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_rx = rd_go && s_axi_araddr == `SIC_OFS_RXDATA;
  wire rd_st = rd_go && s_axi_araddr == `SIC_OFS_STATUS;

  // Current select and its configuration
  wire dec = mode_r[`SIC_M_DECODE];
  wire [3:0] new_pcs = mode_r[`SIC_M_VARSEL] ? tx_word[19:16] :
                       mode_r[`SIC_M_PCS_HI:`SIC_M_PCS_LO];
  wire new_last = mode_r[`SIC_M_VARSEL] & tx_word[20];
  wire [31:0] ncfg = cfg_r[cfg_idx(new_pcs, dec)];
  wire [31:0] ccfg = cfg_r[cfg_idx(cur_pcs_r, dec)];
  wire [7:0] div = ccfg[`SIC_C_DIV_HI:`SIC_C_DIV_LO];
  // Divider of one cannot toggle a registered clock; stretch to two
  wire [7:0] per = (div < 8'h02) ? 8'h02 : div;
  wire [7:0] mid = per >> 1;
  wire [7:0] ndiv = ncfg[`SIC_C_DIV_HI:`SIC_C_DIV_LO];
  wire [7:0] nmid = (ndiv < 8'h02) ? 8'h01 : (ndiv >> 1);
  wire [7:0] ndbs = ncfg[`SIC_C_DBS_HI:`SIC_C_DBS_LO];
  wire [7:0] dct = ccfg[`SIC_C_DCT_HI:`SIC_C_DCT_LO];
  // Gap: 32 x field plus half divider, none when field is zero
  wire [13:0] gap = (dct == 8'h00) ? 14'h0000 :
                    (`SIC_GAP_MULT * {6'h00, dct}) +
                    {7'h00, div[7:1]};
  wire [4:0] nbits = `SIC_BASE_BITS +
                     {1'b0, ccfg[`SIC_C_BITS_HI:`SIC_C_BITS_LO]};
  wire [4:0] nnbits = `SIC_BASE_BITS +
                      {1'b0, ncfg[`SIC_C_BITS_HI:`SIC_C_BITS_LO]};
  wire same_sel = tx_valid && new_pcs == cur_pcs_r;
  wire cont_ok = !cur_last_r && same_sel;
  wire shift_end = st_r == S_SHIFT && cnt_r == {6'h00, per} - 14'h0001 &&
                   bit_r == nbits - 5'h01;
  wire gap_end = st_r == S_GAP && cnt_r == 14'h0000;
  wire lead_load = st_r == S_IDLE && tx_valid && cs_act_r && same_sel;
  wire start_new = st_r == S_IDLE && tx_valid && !cs_act_r;
  // Last bit of a character is sampled in this cycle
  wire rx_done = cap2_r && capl2_r;
  assign tx_pop = lead_load || start_new ||
                  (shift_end && gap == 14'h0000 && cont_ok) ||
                  (gap_end && cont_ok);
  // Left-align the word so the first bit always leaves from bit 15
  wire [15:0] load_sh = tx_word[15:0] << (5'h10 - nnbits);
  assign mosi = sh_r[15];

  // Status flags and interrupt
  wire shifter_empty = st_r == S_IDLE && !tx_valid;
  wire [9:0] status = {shifter_empty, selrise_r, dma_flags, ovr_r, mode_fault_flag_r,
                       tx_in_ready, rxfull_r};
  assign irq = |(status & mask_r);

  // Register file writes and sticky flags; a set wins over its clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= `SIC_RST_MODE;
      for (i = 0; i < 4; i = i + 1)
        cfg_r[i] <= `SIC_RST_CFG;
      mask_r <= `SIC_RST_MASK;
      rxfull_r <= 1'b0;
      ovr_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      selrise_r <= 1'b0;
      rxdata_r <= 16'h0000;
      rxpcs_r <= 4'h0;
    end else begin
      if (wr_go && s_axi_awaddr == `SIC_OFS_MODE)
        mode_r <= (mode_r & ~wm) | wd;
      if (wr_cfg)
        cfg_r[wr_ci] <= ((cfg_r[wr_ci] & ~wm) | wd) & `SIC_CFG_WMASK;
      if (wr_go && s_axi_awaddr == `SIC_OFS_IEN_SET)
        mask_r <= mask_r | wd[9:0];
      else if (wr_go && s_axi_awaddr == `SIC_OFS_IEN_CLR)
        mask_r <= mask_r & ~wd[9:0];
      if (rx_done) begin
        rxdata_r <= {rxsh_r[14:0], miso_s2_r};
        rxpcs_r <= cur_pcs_r;
        rxfull_r <= 1'b1;
      end else if (rd_rx)
        rxfull_r <= 1'b0;
      // Overrun: a second load before the first was read
      if (rx_done && rxfull_r && !rd_rx)
        ovr_r <= 1'b1;
      else if (rd_st)
        ovr_r <= 1'b0;
      if (mode_fault_evt)
        mode_fault_flag_r <= 1'b1;
      else if (rd_st)
        mode_fault_flag_r <= 1'b0;
      if (nss_s2_r && !nss_d_r)
        selrise_r <= 1'b1;
      else if (rd_st)
        selrise_r <= 1'b0;
    end
  end

  // Bus answers: one cycle after the handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == `SIC_OFS_MODE ||
                        s_axi_awaddr == `SIC_OFS_TXDATA ||
                        s_axi_awaddr == `SIC_OFS_IEN_SET ||
                        s_axi_awaddr == `SIC_OFS_IEN_CLR || wr_cfg) ?
                       2'h0 : 2'h3;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `SIC_OFS_MODE: s_axi_rdata <= mode_r;
          `SIC_OFS_RXDATA: s_axi_rdata <= {12'h000, rxpcs_r, rxdata_r};
          `SIC_OFS_STATUS: s_axi_rdata <= {22'h000000, status};
          `SIC_OFS_IEN_RB: s_axi_rdata <= {22'h000000, mask_r};
          8'h30, 8'h34, 8'h38, 8'h3c: s_axi_rdata <= cfg_r[s_axi_araddr[3:2]];
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Pin synchronisers
  always @(posedge aclk) begin
    if (!aresetn) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
      nss_s1_r <= 1'b1;
      nss_s2_r <= 1'b1;
      nss_d_r <= 1'b1;
    end else begin
      miso_s1_r <= miso;
      miso_s2_r <= miso_s1_r;
      nss_s1_r <= select_input_n;
      nss_s2_r <= nss_s1_r;
      nss_d_r <= nss_s2_r;
    end
  end

  // Transfer engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_IDLE;
      cnt_r <= 14'h0000;
      bit_r <= 5'h00;
      sh_r <= 16'h0000;
      rxsh_r <= 16'h0000;
      cs_act_r <= 1'b0;
      cur_last_r <= 1'b0;
      cur_pcs_r <= 4'hf;
      serial_clock <= 1'b0;
      cap1_r <= 1'b0;
      cap2_r <= 1'b0;
      capl1_r <= 1'b0;
      capl2_r <= 1'b0;
    end else begin
      // Sample two cycles after mid-bit: miso lags by its two flops,
      // which keeps short dividers from taking the previous bit
      cap1_r <= st_r == S_SHIFT && cnt_r == {6'h00, mid};
      capl1_r <= bit_r == nbits - 5'h01;
      cap2_r <= cap1_r;
      capl2_r <= cap1_r && capl1_r;
      if (cap2_r)
        rxsh_r <= {rxsh_r[14:0], miso_s2_r};
      case (st_r)
        S_IDLE: begin
          serial_clock <= ccfg[`SIC_C_IDLE];
          if (tx_valid && cs_act_r && !same_sel) begin
            cs_act_r <= 1'b0;
            cnt_r <= `SIC_SWITCH_CYC - 14'h0001;
            st_r <= S_SWITCH;
          end else if (lead_load) begin
            sh_r <= load_sh;
            cur_last_r <= new_last;
            bit_r <= 5'h00;
            cnt_r <= 14'h0000;
            st_r <= S_SHIFT;
          end else if (start_new) begin
            cs_act_r <= 1'b1;
            cur_pcs_r <= new_pcs;
            cur_last_r <= new_last;
            sh_r <= load_sh;
            bit_r <= 5'h00;
            serial_clock <= ncfg[`SIC_C_IDLE];
            cnt_r <= {6'h00, (ndbs == 8'h00) ? nmid : ndbs} -
                     14'h0001;
            st_r <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (cnt_r == 14'h0000)
            st_r <= S_SHIFT;
          else
            cnt_r <= cnt_r - 14'h0001;
        end
        S_SHIFT: begin
          // Phase 0: active first half; phase 1: active second half
          serial_clock <= ccfg[`SIC_C_IDLE] ^ (ccfg[`SIC_C_PHASE] ?
                          (cnt_r >= {6'h00, mid}) :
                          (cnt_r < {6'h00, mid}));
          if (cnt_r == {6'h00, per} - 14'h0001) begin
            cnt_r <= 14'h0000;
            if (bit_r != nbits - 5'h01) begin
              bit_r <= bit_r + 5'h01;
              sh_r <= {sh_r[14:0], 1'b0};
            end else if (gap == 14'h0000 && cont_ok) begin
              bit_r <= 5'h00;
              sh_r <= load_sh;
              cur_last_r <= new_last;
            end else begin
              cnt_r <= (gap == 14'h0000) ? 14'h0000 :
                       gap - 14'h0001;
              st_r <= S_GAP;
            end
          end else
            cnt_r <= cnt_r + 14'h0001;
        end
        S_GAP: begin
          serial_clock <= ccfg[`SIC_C_IDLE];
          if (cnt_r != 14'h0000)
            cnt_r <= cnt_r - 14'h0001;
          else if (cont_ok) begin
            sh_r <= load_sh;
            cur_last_r <= new_last;
            bit_r <= 5'h00;
            st_r <= S_SHIFT;
          end else if (cur_last_r || tx_valid ||
                       !ccfg[`SIC_C_HOLD]) begin
            cs_act_r <= 1'b0;
            cnt_r <= `SIC_SWITCH_CYC - 14'h0001;
            st_r <= S_SWITCH;
          end else
            st_r <= S_IDLE;
        end
        S_SWITCH: begin
          if (cnt_r == 14'h0000)
            st_r <= S_IDLE;
          else
            cnt_r <= cnt_r - 14'h0001;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Select pins: raw code when decoding, else one line low per code
  always @(posedge aclk) begin
    if (!aresetn)
      peripheral_select_lines_n <= 4'hf;
    else if (!cs_act_r)
      peripheral_select_lines_n <= 4'hf;
    else if (dec)
      peripheral_select_lines_n <= cur_pcs_r;
    else if (!cur_pcs_r[0])
      peripheral_select_lines_n <= 4'he;
    else if (!cur_pcs_r[1])
      peripheral_select_lines_n <= 4'hd;
    else if (!cur_pcs_r[2])
      peripheral_select_lines_n <= 4'hb;
    else
      peripheral_select_lines_n <= 4'h7;
  end
endmodule

// [shared/sic_defines.vh]
// Summary of operation
// - Writing one to an enable-set bit sets that mask bit; zero leaves it.
// - Writing one to an enable-clear bit clears that mask bit; zero leaves it.
// - Mask readback returns one for each enabled source, zero otherwise.
// - Set, clear, readback share layout: bits 0-7 data flags, 8 select rise, 9 empty.
// - Clock idle level bit selects serial clock idle low (0) or high (1).
// - Phase bit 0 changes on leading edge; 1 captures on leading edge.
// - Hold bit 0 releases select after transfer; 1 holds until other select or a word with the last flag.
// - Length field gives 8 plus value bits, 0000 to 1000; others reserved.
// - Serial clock is master clock divided by divider field, 2 to 255; 0 and 1 divide by 2.
// - Select-to-clock delay is half serial period if zero, else field cycles.
// - Inter-character delay follows every character, also before select release.
// - Zero inter-character delay inserts no gap, clock keeps its duty cycle.
// - Nonzero gap lasts 32 times field plus half divider master cycles.
// - With decoding on, config register n governs decoded selects 4n to 4n+3.
// - Shifter empty sets once shifter, gap and select switch are done and no word waits; a held select may stay low.
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH
// Byte offsets on the register bus
`define SIC_OFS_MODE 8'h00
`define SIC_OFS_RXDATA 8'h08
`define SIC_OFS_TXDATA 8'h0c
`define SIC_OFS_STATUS 8'h10
`define SIC_OFS_IEN_SET 8'h14
`define SIC_OFS_IEN_CLR 8'h18
`define SIC_OFS_IEN_RB 8'h1c
`define SIC_OFS_CFG0 8'h30
// Flag positions shared by status and mask registers
`define SIC_NFLAGS 10
`define SIC_F_RXFULL 0
`define SIC_F_TXHEMPTY 1
`define SIC_F_MODE_FAULT_FLAG 2
`define SIC_F_OVR 3
`define SIC_F_EXT_LO 4
`define SIC_F_SELRISE 8
`define SIC_F_SHEMPTY 9
// Select config fields
`define SIC_C_IDLE 0
`define SIC_C_PHASE 1
`define SIC_C_HOLD 3
`define SIC_C_BITS_HI 7
`define SIC_C_BITS_LO 4
`define SIC_C_DIV_HI 15
`define SIC_C_DIV_LO 8
`define SIC_C_DBS_HI 23
`define SIC_C_DBS_LO 16
`define SIC_C_DCT_HI 31
`define SIC_C_DCT_LO 24
`define SIC_CFG_WMASK 32'hfffffffb
// Mode fields
`define SIC_M_DECODE 0
`define SIC_M_VARSEL 1
`define SIC_M_PCS_HI 19
`define SIC_M_PCS_LO 16
// Transmit word fields
`define SIC_T_LAST 24
// Reset values
`define SIC_RST_CFG 32'h00000000
`define SIC_RST_MODE 32'h00000000
`define SIC_RST_MASK 10'h000
// Timing
`define SIC_GAP_MULT 14'h0020
`define SIC_SWITCH_CYC 14'h0006
`define SIC_BASE_BITS 5'h08
`endif

// [tb/sic_checker.sv]
`timescale 1ns/1ps
module sic_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Serial side and interrupt
  input wire [3:0] peripheral_select_lines_n,
  input wire irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Set-only enable register offset
  localparam [7:0] OFS_SET = 8'h14;
  wire [3:0] sel = peripheral_select_lines_n;
  // Release: all selects high right after one was low
  sequence s_release;
    sel == 4'hf && $past(sel) != 4'hf;
  endsequence
  // Quiet: no select taken while peripherals float off
  sequence s_quiet;
    (sel == 4'hf)[*4];
  endsequence
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready
    |=> s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  wo_read_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == OFS_SET |=> s_axi_rresp == 2'b11)
    else $error("write-only read answered okay");
  mask_reset_a: assert property ($rose(aresetn)
    |-> !irq && sel == 4'hf) else $error("irq or select after reset");
  sel_switch_a: assert property ($changed(sel)
    |-> sel == 4'hf || $past(sel) == 4'hf) else $error("select overlap");
  sel_gap_a: assert property (s_release |=> s_quiet)
    else $error("select switch too fast");
endmodule

bind sic_top sic_checker i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .peripheral_select_lines_n(peripheral_select_lines_n),
  .irq(irq)
);

// [tb/sic_periph_model.sv]
`timescale 1ns/1ps
module sic_periph_model (
  // Serial pins
  input wire serial_clock,
  input wire mosi,
  input wire sel_n,
  output reg miso,
  // Mode and data
  input wire clock_idle_level,
  input wire capture_edge_select,
  input wire [4:0] nbits,
  input wire [15:0] tx_word,
  output reg [15:0] rx_word
);
  int idx;
  reg on;
  initial miso = 1'b0;
  // Frame start; an idle-level fix-up before the first lead is ignored
  always @(negedge sel_n) begin
    rx_word = 16'h0000;
    on = 1'b0;
    idx = capture_edge_select ? 0 : -1;
    miso = capture_edge_select ? tx_word[nbits - 1] : ~miso;
  end
  // Capture on one edge kind, shift out on the other
  always @(serial_clock) if (!sel_n && (on || serial_clock != clock_idle_level)) begin
    on = 1'b1;
    if ((serial_clock != clock_idle_level) == capture_edge_select)
      rx_word = {rx_word[14:0], mosi};
    else begin
      idx = idx + 1;
      miso = idx < nbits ? tx_word[nbits - 1 - idx] : ~miso;
    end
  end
  // Released line shows no stale bit
  always @(posedge sel_n) miso = ~miso;
endmodule

// [tb/tb_spi_irq_mask_and_cs_timing.sv]
`timescale 1ns/1ps
`include "sic_defines.vh"
module tb_spi_irq_mask_and_cs_timing;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0;
  reg mode_fault_evt = 1'b0;
  reg [3:0] dma_flags = 4'h0;
  reg clock_idle_level = 1'b0, capture_edge_select = 1'b1, sel_q = 1'b1, sck_q = 1'b0, seen;
  reg [4:0] nbits = 5'h08;
  reg [31:0] rv, rr, br, c, m;
  reg [31:0] cfgs [0:2] = '{32'h00020402, 32'h01000383, 32'h00050848};
  wire awready, wready, bvalid, arready, rvalid, sclk, mosi, miso, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] sel_n;
  wire [15:0] mrx;
  int failures = 0, n_compared = 0, i, cyc = 0, t0, tl, nl, lead, per;
  int tc = 0, rel = 0;

  always #5 aclk = ~aclk;

  sic_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock(sclk), .mosi(mosi), .miso(miso),
    .peripheral_select_lines_n(sel_n), .select_input_n(1'b1),
    .mode_fault_evt(mode_fault_evt), .dma_flags(dma_flags), .irq(irq)
  );

  sic_periph_model i_peer (
    .serial_clock(sclk), .mosi(mosi), .sel_n(sel_n[0]), .miso(miso),
    .clock_idle_level(clock_idle_level), .capture_edge_select(capture_edge_select), .nbits(nbits),
    .tx_word(16'h3c5a), .rx_word(mrx)
  );

  task chk(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0t got %h expected %h", $time, g, e);
      end
    end
  endtask

  // Write: ready is seen at the negedge, taken at the next rising edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do @(negedge aclk); while (awready !== 1'b1);
      @(posedge aclk);
      awvalid <= 1'b0; wvalid <= 1'b0;
      do @(negedge aclk); while (bvalid !== 1'b1);
      @(posedge aclk) bready <= 1'b1;
      @(posedge aclk) bready <= 1'b0;
      br = {30'h0, bresp};
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk) arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      @(posedge aclk) rready <= 1'b1;
      @(posedge aclk) rready <= 1'b0;
      rv = rdata;
      rr = {30'h0, rresp};
    end
  endtask

  task tally_and_finish;
    begin
      if (failures == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Leading edges of the serial clock: count, spacing, delay after select
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (sel_n[0] === 1'b0 && sel_q === 1'b1) begin
      t0 = cyc; nl = 0;
    end
    if (sclk !== sck_q && sclk !== clock_idle_level) begin
      if (nl == 0) lead = cyc - t0;
      else per = cyc - tl;
      tl = cyc; nl = nl + 1;
    end
    if (sclk !== sck_q) tc = cyc;
    if (sel_n[0] === 1'b1 && sel_q === 1'b0) rel = cyc - tc;
    sel_q = sel_n[0]; sck_q = sclk;
  end

  // Watchdog, far beyond the slowest transfer
  initial begin
    repeat (60000) @(posedge aclk);
    failures = failures + 1;
    tally_and_finish;
  end

  // Mask set/clear, interrupt, bus errors, config, then transfers
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk); chk(irq, 1'b0);
    rd(8'h1c); chk(rv, 32'h0);
    for (i = 0; i < 10; i = i + 1) begin
      wr(8'h14, 32'h1 << i);
      rd(8'h1c); chk(rv, (32'h2 << i) - 1);
    end
    wr(8'h14, 32'hffffffff);
    rd(8'h1c); chk(rv, 32'h3ff);
    wr(8'h18, 32'h155);
    rd(8'h1c); chk(rv, 32'h2aa);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    rd(8'h1c); chk(rv, 32'h2aa);
    @(negedge aclk); chk(irq, 1'b1);
    wr(8'h18, 32'h3ff);
    @(negedge aclk); chk(irq, 1'b0);
    wr(8'h14, 32'h4);
    @(posedge aclk) mode_fault_evt <= 1'b1;
    @(posedge aclk) mode_fault_evt <= 1'b0;
    @(negedge aclk); chk(irq, 1'b1);
    rd(8'h10);
    @(negedge aclk); chk(irq, 1'b0);
    @(posedge aclk) dma_flags <= 4'h1;
    wr(8'h14, 32'h10);
    @(negedge aclk); chk(irq, 1'b1);
    wr(8'h18, 32'h10);
    @(negedge aclk); chk(irq, 1'b0);
    @(posedge aclk) dma_flags <= 4'h0;
    rd(8'h44); chk(rr, 32'h3);
    rd(8'h14); chk(rr, 32'h3);
    wr(8'h44, 32'h1); chk(br, 32'h3);
    for (i = 0; i < 4; i = i + 1) begin
      rd(8'h30 + 4 * i); chk(rv, 32'h0);
      wr(8'h30 + 4 * i, 32'hffffff8f);
      rd(8'h30 + 4 * i); chk(rv, 32'hffffff8f & `SIC_CFG_WMASK);
    end
    wr(8'h00, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      c = cfgs[i];
      clock_idle_level <= c[0]; capture_edge_select <= c[1]; nbits <= 5'h08 + c[7:4];
      wr(8'h30, c);
      wr(8'h0c, 32'h0000c3a5);
      while (sel_n[0] !== 1'b0) @(posedge aclk);
      do rd(8'h10); while (rv[9] !== 1'b1);
      rd(8'h08);
      m = (32'h1 << (8 + c[7:4])) - 1;
      chk(rv & m, 32'h3c5a & m);
      chk({16'h0, mrx} & m, 32'hc3a5 & m);
      chk(nl, 8 + c[7:4]);
      chk(per, c[15:8]);
      chk(lead >= (c[23:16] ? c[23:16] : c[15:8] / 2), 1);
      @(negedge aclk); chk(sel_n[0], !c[3]);
      if (!c[3]) chk(sclk, c[0]);
      if (!c[3])
        chk(rel, c[31:24] ? 32 * c[31:24] + c[15:8] / 2 : 1);
    end
    wr(8'h34, 32'h00000400);
    wr(8'h00, 32'h00010000);
    wr(8'h0c, 32'h0000c3a5);
    seen = 1'b0;
    while (sel_n !== 4'b1101) begin
      if (sel_n === 4'hf) seen = 1'b1;
      @(posedge aclk);
    end
    chk(seen, 1'b1);
    // Decoded code 1001 must take the third config (idle high)
    do rd(8'h10); while (rv[9] !== 1'b1);
    wr(8'h00, 32'h00090001);
    wr(8'h0c, 32'h0000c3a5);
    while (sel_n !== 4'b1001) @(posedge aclk);
    @(negedge aclk); chk(sclk, 1'b1);
    tally_and_finish;
  end
endmodule
